// ---- fpga_config_pin_control.sv ----
/*
 * Configuration pin controller: done line, reconfiguration trigger, mode
 * sensing, flash chip selects, data line directions, configuration clock,
 * chain selects, error status and the test access port.
 * Assumes all pins arrive asynchronously and the core consumes words.
 */
// Contract
// - done line is open drain, held low until loading finishes.
// - user mode waits until the shared done line really reads high.
// - test port samples TMS and TDI on rising TCK.
// - TDO changes only after a falling TCK edge.
// - TDO is not driven unless shifting.
// - undriven TMS and TDI read as one.
// - TDI shifts into instruction or data register; TDO comes from same one.
// - image select 00..11 picks images one to four.
// - image select ignored for single image or remote update.
// - chain select in low refuses configuration; high allows it.
// - chain select out asserts once own configuration completes.
// - error output low on identity mismatch, CRC failure or update failure.
// - mode pin sampled at trigger release: zero passive, one active.
// - in active mode the mode pin becomes lower flash chip select.
// - x8 active mode drives the upper flash chip select.
// - line zero output in x1 active, bidirectional in other active widths, input only in passive; line four in x8.
// - data bus up to 32 lines, used according to selected width.
// - clock pin is input in passive mode, output in active mode.
// - active mode may derive its clock from the alternative clock input.
// - chain select out low in reset and loading, high after bitstream ends.
`default_nettype none

`include "cfg_pins_cfg.svh"

module fpga_config_pin_control (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       reconfig_n,
	input  wire logic                       config_done_in,
	output logic                            config_done_out,
	output logic                            config_done_oe,
	input  wire logic                       chain_select_in,
	output logic                            chain_select_out,
	output logic                            config_error_n,
	input  wire logic                       mode_sense_lower_flash_cs_n_in,
	output logic                            mode_sense_lower_flash_cs_n_out,
	output logic                            mode_sense_lower_flash_cs_n_oe,
	output logic                            upper_flash_cs_n,
	input  wire logic                       config_clock_pin_in,
	output logic                            config_clock_pin_out,
	output logic                            config_clock_pin_oe,
	input  wire logic [31:0]                config_data_lines_in,
	output logic      [31:0]                config_data_lines_out,
	output logic      [31:0]                config_data_lines_oe,
	input  wire logic                       alt_config_clock,
	input  wire logic                       alt_clock_en,
	input  wire cfg_pins_pkg::width_t       bus_width,
	input  wire logic                       multi_image_en,
	input  wire logic                       remote_update,
	input  wire logic [1:0]                 remote_image,
	input  wire logic [1:0]                 image_select,
	input  wire logic                       test_mode_n,
	input  wire logic                       id_mismatch,
	input  wire logic                       crc_fail,
	input  wire logic                       update_fail,
	input  wire logic                       bitstream_end,
	output logic      [31:0]                word_data,
	output logic                            word_valid,
	input  wire logic                       word_ready,
	output logic      [1:0]                 image_index,
	output logic                            user_mode,
	input  wire logic                       tck,
	input  wire logic                       tms,
	input  wire logic                       tdi,
	output logic                            tdo,
	output logic                            tdo_oe
);

	localparam cfg_pins_pkg::sense_t SENSE_RST = '{tms: 1'b1, tdi: 1'b1, default: '0};
	localparam logic [3:0] HALF_LAST = 4'(`CFG_ACT_HALF_CYC - 1);

	// three-stage pin sampling with agreement filter
	cfg_pins_pkg::sense_t s1_reg;
	cfg_pins_pkg::sense_t s2_reg;
	cfg_pins_pkg::sense_t s3_reg;
	cfg_pins_pkg::sense_t f_reg;
	cfg_pins_pkg::sense_t f_next;
	cfg_pins_pkg::sense_t raw;

	assign raw = '{reconfig_n: reconfig_n, mode: mode_sense_lower_flash_cs_n_in, done: config_done_in,
		chain_in: chain_select_in, test_n: test_mode_n, cclk: config_clock_pin_in,
		alt_clk: alt_config_clock, tck: tck, tms: tms, tdi: tdi, image: image_select,
		data: config_data_lines_in};

	always_comb
	begin
		f_next = (s2_reg & s3_reg) | (f_reg & (s2_reg | s3_reg));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_reg <= SENSE_RST;
			s2_reg <= SENSE_RST;
			s3_reg <= SENSE_RST;
			f_reg  <= SENSE_RST;
		end
		else
		begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			f_reg  <= f_next;
		end
	end

	logic cclk_rise;
	logic alt_rise;
	logic tck_rise;
	logic tck_fall;

	assign cclk_rise = f_next.cclk && !f_reg.cclk;
	assign alt_rise  = f_next.alt_clk && !f_reg.alt_clk;
	assign tck_rise  = f_next.tck && !f_reg.tck;
	assign tck_fall  = !f_next.tck && f_reg.tck;

	function automatic logic [5:0] lane_bits(input cfg_pins_pkg::width_t w);
		case (w)
			cfg_pins_pkg::W1:  lane_bits = 6'h01;
			cfg_pins_pkg::W2:  lane_bits = 6'h02;
			cfg_pins_pkg::W4:  lane_bits = 6'h04;
			cfg_pins_pkg::W8:  lane_bits = 6'h08;
			cfg_pins_pkg::W16: lane_bits = 6'h10;
			default:           lane_bits = 6'h20;
		endcase
	endfunction : lane_bits

	function automatic logic [31:0] append(input logic [31:0] word, input logic [31:0] d,
		input cfg_pins_pkg::width_t w, input logic active);
		case (w)
			cfg_pins_pkg::W1:  append = {word[30:0], active ? d[1] : d[0]};
			cfg_pins_pkg::W2:  append = {word[29:0], d[1:0]};
			cfg_pins_pkg::W4:  append = {word[27:0], d[3:0]};
			cfg_pins_pkg::W8:  append = {word[23:0], d[7:0]};
			cfg_pins_pkg::W16: append = {word[15:0], d[15:0]};
			default:           append = d;
		endcase
	endfunction : append

	// load sequencer
	cfg_pins_pkg::load_state_t state_reg;
	cfg_pins_pkg::load_state_t state_next;
	logic        mode_reg;
	logic        mode_next;
	logic [1:0]  image_reg;
	logic [1:0]  image_next;
	logic        error_reg;
	logic        error_next;
	logic        cso_reg;
	logic        cso_next;
	logic        done_oe_reg;
	logic        done_oe_next;
	logic        csl_reg;
	logic        csl_next;
	logic        csu_reg;
	logic        csu_next;
	logic        cclk_reg;
	logic        cclk_next;
	logic [3:0]  div_reg;
	logic [3:0]  div_next;
	logic [5:0]  cmdcnt_reg;
	logic [5:0]  cmdcnt_next;
	logic [31:0] cmd_reg;
	logic [31:0] cmd_next;
	logic [31:0] word_reg;
	logic [31:0] word_next;
	logic [5:0]  fill_reg;
	logic [5:0]  fill_next;
	logic        push_valid;
	logic        push_ready;
	logic [31:0] push_word;
	logic        tick;
	logic        gen_rise;
	logic        gen_fall;
	logic        sample;
	logic        word_full;
	logic        x8;
	logic        running;

	assign x8        = bus_width == cfg_pins_pkg::W8;
	assign running   = mode_reg && (state_reg == cfg_pins_pkg::ST_CMD || state_reg == cfg_pins_pkg::ST_LOAD);
	assign tick      = alt_clock_en ? alt_rise : div_reg == HALF_LAST;
	// rising edge held back while the buffer cannot accept a word
	assign gen_rise  = running && tick && !cclk_reg && push_ready;
	assign gen_fall  = running && tick && cclk_reg;
	assign sample    = state_reg == cfg_pins_pkg::ST_LOAD && (mode_reg ? gen_rise : cclk_rise);
	assign word_full = fill_reg + lane_bits(bus_width) == 6'h20;
	assign push_word = append(word_reg, f_reg.data, bus_width, mode_reg);
	assign push_valid = sample && (word_full || bus_width == cfg_pins_pkg::W32);

	always_comb
	begin
		state_next   = state_reg;
		mode_next    = mode_reg;
		image_next   = image_reg;
		error_next   = error_reg;
		cso_next     = cso_reg;
		done_oe_next = done_oe_reg;
		csl_next     = csl_reg;
		csu_next     = csu_reg;
		cclk_next    = cclk_reg;
		div_next     = (running && !tick && !alt_clock_en) ? div_reg + 4'h1 : 4'h0;
		cmdcnt_next  = cmdcnt_reg;
		cmd_next     = cmd_reg;
		word_next    = word_reg;
		fill_next    = fill_reg;
		if (gen_rise)
			cclk_next = 1'b1;
		if (gen_fall)
			cclk_next = 1'b0;
		if (sample)
		begin
			word_next = push_word;
			fill_next = push_valid ? 6'h00 : fill_reg + lane_bits(bus_width);
		end
		if (id_mismatch || crc_fail || update_fail)
			error_next = 1'b1;
		if (push_valid && !push_ready)
			error_next = 1'b1;
		if (!f_reg.reconfig_n)
		begin
			state_next   = cfg_pins_pkg::ST_RESET;
			error_next   = 1'b0;
			cso_next     = 1'b0;
			done_oe_next = 1'b1;
			csl_next     = 1'b1;
			csu_next     = 1'b1;
			cclk_next    = 1'b0;
			fill_next    = 6'h00;
		end
		else
		begin
			case (state_reg)
				cfg_pins_pkg::ST_RESET:
				begin
					// first cycle after the trigger is released
					mode_next  = f_reg.mode;
					image_next = (multi_image_en && !remote_update) ? f_reg.image :
						(remote_update ? remote_image : 2'h0);
					state_next = cfg_pins_pkg::ST_IDLE;
				end
				cfg_pins_pkg::ST_IDLE:
				begin
					if (f_reg.chain_in && f_reg.test_n)
					begin
						if (mode_reg)
						begin
							csl_next    = 1'b0;
							csu_next    = !x8;
							cmd_next    = {`CFG_READ_CMD, 24'(image_reg) << `CFG_IMG_ADDR_LSB};
							cmdcnt_next = 6'h00;
							state_next  = cfg_pins_pkg::ST_CMD;
						end
						else
							state_next = cfg_pins_pkg::ST_LOAD;
					end
				end
				cfg_pins_pkg::ST_CMD:
				begin
					if (gen_fall && cclk_reg)
					begin
						cmd_next    = {cmd_reg[30:0], 1'b0};
						cmdcnt_next = cmdcnt_reg + 6'h01;
						if (cmdcnt_reg == 6'(`CFG_CMD_BITS - 1))
							state_next = cfg_pins_pkg::ST_LOAD;
					end
				end
				cfg_pins_pkg::ST_LOAD:
				begin
					if (!f_reg.chain_in)
					begin
						csl_next   = 1'b1;
						csu_next   = 1'b1;
						cclk_next  = 1'b0;
						fill_next  = 6'h00;
						state_next = cfg_pins_pkg::ST_IDLE;
					end
					else if (bitstream_end)
					begin
						csl_next     = 1'b1;
						csu_next     = 1'b1;
						cclk_next    = 1'b0;
						cso_next     = 1'b1;
						done_oe_next = 1'b0;
						state_next   = cfg_pins_pkg::ST_RELEASE;
					end
				end
				cfg_pins_pkg::ST_RELEASE:
				begin
					if (f_reg.done)
						state_next = cfg_pins_pkg::ST_USER;
				end
				default:
				begin
					state_next = cfg_pins_pkg::ST_USER;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg   <= cfg_pins_pkg::ST_RESET;
			mode_reg    <= 1'b0;
			image_reg   <= 2'h0;
			error_reg   <= 1'b0;
			cso_reg     <= 1'b0;
			done_oe_reg <= 1'b1;
			csl_reg     <= 1'b1;
			csu_reg     <= 1'b1;
			cclk_reg    <= 1'b0;
			div_reg     <= 4'h0;
			cmdcnt_reg  <= 6'h00;
			cmd_reg     <= 32'h0000_0000;
			word_reg    <= 32'h0000_0000;
			fill_reg    <= 6'h00;
		end
		else
		begin
			state_reg   <= state_next;
			mode_reg    <= mode_next;
			image_reg   <= image_next;
			error_reg   <= error_next;
			cso_reg     <= cso_next;
			done_oe_reg <= done_oe_next;
			csl_reg     <= csl_next;
			csu_reg     <= csu_next;
			cclk_reg    <= cclk_next;
			div_reg     <= div_next;
			cmdcnt_reg  <= cmdcnt_next;
			cmd_reg     <= cmd_next;
			word_reg    <= word_next;
			fill_reg    <= fill_next;
		end
	end

	cfg_word_fifo #(
		.WIDTH (`CFG_WORD_BITS),
		.DEPTH (`CFG_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_word),
		.out_valid (word_valid),
		.out_ready (word_ready),
		.out_data  (word_data)
	);

	logic pins_active;
	logic in_cmd;

	assign pins_active = mode_reg && state_reg != cfg_pins_pkg::ST_RESET && state_reg != cfg_pins_pkg::ST_USER;
	assign in_cmd      = mode_reg && state_reg == cfg_pins_pkg::ST_CMD;

	assign config_done_out                 = 1'b0;
	assign config_done_oe                  = done_oe_reg;
	assign chain_select_out                = cso_reg;
	assign config_error_n                  = !error_reg;
	assign image_index                     = image_reg;
	assign user_mode                       = state_reg == cfg_pins_pkg::ST_USER;
	assign mode_sense_lower_flash_cs_n_out = csl_reg;
	assign mode_sense_lower_flash_cs_n_oe  = pins_active;
	assign upper_flash_cs_n                = csu_reg;
	assign config_clock_pin_out            = cclk_reg;
	assign config_clock_pin_oe             = running;

	always_comb
	begin
		config_data_lines_out    = 32'h0000_0000;
		config_data_lines_oe     = 32'h0000_0000;
		config_data_lines_out[0] = cmd_reg[31];
		config_data_lines_out[4] = cmd_reg[31];
		config_data_lines_oe[0]  = in_cmd || (running && bus_width == cfg_pins_pkg::W1);
		config_data_lines_oe[4]  = in_cmd && x8;
	end

	// test access port
	cfg_pins_pkg::tap_state_t tap_reg;
	cfg_pins_pkg::tap_state_t tap_next;
	logic [3:0]  ir_reg;
	logic [3:0]  ir_next;
	logic [3:0]  irsh_reg;
	logic [3:0]  irsh_next;
	logic [31:0] dr_reg;
	logic [31:0] dr_next;
	logic        tdo_reg;
	logic        tdo_next;
	logic        tdo_oe_reg;
	logic        tdo_oe_next;

	function automatic cfg_pins_pkg::tap_state_t tap_step(input cfg_pins_pkg::tap_state_t s, input logic m);
		case (s)
			cfg_pins_pkg::T_RESET:  tap_step = m ? cfg_pins_pkg::T_RESET : cfg_pins_pkg::T_IDLE;
			cfg_pins_pkg::T_IDLE:   tap_step = m ? cfg_pins_pkg::T_SEL_DR : cfg_pins_pkg::T_IDLE;
			cfg_pins_pkg::T_SEL_DR: tap_step = m ? cfg_pins_pkg::T_SEL_IR : cfg_pins_pkg::T_CAP_DR;
			cfg_pins_pkg::T_CAP_DR: tap_step = m ? cfg_pins_pkg::T_EX1_DR : cfg_pins_pkg::T_SH_DR;
			cfg_pins_pkg::T_SH_DR:  tap_step = m ? cfg_pins_pkg::T_EX1_DR : cfg_pins_pkg::T_SH_DR;
			cfg_pins_pkg::T_EX1_DR: tap_step = m ? cfg_pins_pkg::T_UP_DR : cfg_pins_pkg::T_PA_DR;
			cfg_pins_pkg::T_PA_DR:  tap_step = m ? cfg_pins_pkg::T_EX2_DR : cfg_pins_pkg::T_PA_DR;
			cfg_pins_pkg::T_EX2_DR: tap_step = m ? cfg_pins_pkg::T_UP_DR : cfg_pins_pkg::T_SH_DR;
			cfg_pins_pkg::T_UP_DR:  tap_step = m ? cfg_pins_pkg::T_SEL_DR : cfg_pins_pkg::T_IDLE;
			cfg_pins_pkg::T_SEL_IR: tap_step = m ? cfg_pins_pkg::T_RESET : cfg_pins_pkg::T_CAP_IR;
			cfg_pins_pkg::T_CAP_IR: tap_step = m ? cfg_pins_pkg::T_EX1_IR : cfg_pins_pkg::T_SH_IR;
			cfg_pins_pkg::T_SH_IR:  tap_step = m ? cfg_pins_pkg::T_EX1_IR : cfg_pins_pkg::T_SH_IR;
			cfg_pins_pkg::T_EX1_IR: tap_step = m ? cfg_pins_pkg::T_UP_IR : cfg_pins_pkg::T_PA_IR;
			cfg_pins_pkg::T_PA_IR:  tap_step = m ? cfg_pins_pkg::T_EX2_IR : cfg_pins_pkg::T_PA_IR;
			cfg_pins_pkg::T_EX2_IR: tap_step = m ? cfg_pins_pkg::T_UP_IR : cfg_pins_pkg::T_SH_IR;
			default:                tap_step = m ? cfg_pins_pkg::T_SEL_DR : cfg_pins_pkg::T_IDLE;
		endcase
	endfunction : tap_step

	always_comb
	begin
		tap_next    = tap_reg;
		ir_next     = ir_reg;
		irsh_next   = irsh_reg;
		dr_next     = dr_reg;
		tdo_next    = tdo_reg;
		tdo_oe_next = tdo_oe_reg;
		if (tck_rise)
		begin
			tap_next = tap_step(tap_reg, f_reg.tms);
			case (tap_reg)
				cfg_pins_pkg::T_RESET:  ir_next = `CFG_IR_IDCODE;
				cfg_pins_pkg::T_CAP_IR: irsh_next = `CFG_IR_CAPTURE;
				cfg_pins_pkg::T_SH_IR:  irsh_next = {f_reg.tdi, irsh_reg[3:1]};
				cfg_pins_pkg::T_UP_IR:  ir_next = irsh_reg;
				cfg_pins_pkg::T_CAP_DR: dr_next = (ir_reg == `CFG_IR_IDCODE) ? `CFG_IDCODE : 32'h0000_0000;
				cfg_pins_pkg::T_SH_DR:
				begin
					if (ir_reg == `CFG_IR_IDCODE)
						dr_next = {f_reg.tdi, dr_reg[31:1]};
					else
						dr_next = {31'h0000_0000, f_reg.tdi};
				end
				default:
				begin
					dr_next = dr_reg;
				end
			endcase
		end
		if (tck_fall)
		begin
			tdo_next    = (tap_reg == cfg_pins_pkg::T_SH_IR) ? irsh_reg[0] : dr_reg[0];
			tdo_oe_next = tap_reg == cfg_pins_pkg::T_SH_IR || tap_reg == cfg_pins_pkg::T_SH_DR;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tap_reg    <= cfg_pins_pkg::T_RESET;
			ir_reg     <= `CFG_IR_IDCODE;
			irsh_reg   <= 4'h0;
			dr_reg     <= 32'h0000_0000;
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end
		else
		begin
			tap_reg    <= tap_next;
			ir_reg     <= ir_next;
			irsh_reg   <= irsh_next;
			dr_reg     <= dr_next;
			tdo_reg    <= tdo_next;
			tdo_oe_reg <= tdo_oe_next;
		end
	end

	assign tdo    = tdo_reg;
	assign tdo_oe = tdo_oe_reg;

endmodule : fpga_config_pin_control

`default_nettype wire

// ---- cfg_pins_cfg.svh ----
/*
 * Constants for the configuration pin controller: timing counts, widths,
 * the flash read command and the test port instruction codes.
 * Assumes a 100 MHz system clock.
 */
`ifndef CFG_PINS_CFG_SVH
`define CFG_PINS_CFG_SVH

`define CFG_CLK_NS        10
`define CFG_ACT_HALF_NS   40
`define CFG_ACT_HALF_CYC  ((`CFG_ACT_HALF_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS)
`define CFG_WORD_BITS     32
`define CFG_CMD_BITS      32
`define CFG_FIFO_DEPTH    4
`define CFG_READ_CMD      8'h03
`define CFG_IMG_ADDR_LSB  20
`define CFG_IR_BITS       4
`define CFG_IR_IDCODE     4'h1
`define CFG_IR_BYPASS     4'hf
`define CFG_IR_CAPTURE    4'h1
`define CFG_IDCODE        32'h1234_5679 // arbitrary value

`endif

// ---- cfg_pins_pkg.sv ----
/*
 * Types shared by the configuration pin controller.
 * Assumes cfg_pins_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package cfg_pins_pkg;

	typedef enum logic [2:0] {W1, W2, W4, W8, W16, W32} width_t;

	typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_CMD, ST_LOAD, ST_RELEASE, ST_USER} load_state_t;

	typedef enum logic [3:0] {
		T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
		T_UP_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR
	} tap_state_t;

	// pins sampled from outside the clock domain
	typedef struct packed {
		logic        reconfig_n;
		logic        mode;
		logic        done;
		logic        chain_in;
		logic        test_n;
		logic        cclk;
		logic        alt_clk;
		logic        tck;
		logic        tms;
		logic        tdi;
		logic [1:0]  image;
		logic [31:0] data;
	} sense_t;

endpackage : cfg_pins_pkg

`default_nettype wire

// ---- cfg_word_fifo.sv ----
/*
 * Small synchronous FIFO for configuration words.
 * Assumes one clock; DEPTH is a power of two.
 */
`default_nettype none

module cfg_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      wr_next;
	logic [AW:0]      rd_reg;
	logic [AW:0]      rd_next;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_reg != rd_reg;
	assign out_data  = mem_reg[rd_reg[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// storage carries no reset
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg[AW-1:0]] <= in_data;
	end

endmodule : cfg_word_fifo

`default_nettype wire

// ---- cfg_pins_checker_assertions.sv ----
/* port-level assertions for the configuration pin controller
   assumes one clock domain with an active high asynchronous rst */
`default_nettype none
module cfg_pins_checker (
	input wire logic					clk,
	input wire logic					rst,
	input wire logic					reconfig_n,
	input wire logic					config_done_in,
	input wire logic					config_done_oe,
	input wire logic					chain_select_out,
	input wire logic					config_error_n,
	input wire logic					mode_sense_lower_flash_cs_n_out,
	input wire logic					mode_sense_lower_flash_cs_n_oe,
	input wire logic					upper_flash_cs_n,
	input wire logic					config_clock_pin_oe,
	input wire logic [31:0]				config_data_lines_oe,
	input wire cfg_pins_pkg::width_t	bus_width,
	input wire logic					id_mismatch,
	input wire logic					crc_fail,
	input wire logic					update_fail,
	input wire logic					bitstream_end,
	input wire logic					user_mode,
	input wire logic					tck,
	input wire logic					tdo
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	user_done_a: assert property (user_mode |-> !config_done_oe && chain_select_out)
		else $error("user mode while done held");
	sync_start_a: assert property ($rose(user_mode) |-> config_done_in && $past(config_done_in))
		else $error("user mode with done line low");
	tdo_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck, 3))
		else $error("tdo moved outside tck low");
	cso_end_a: assert property ($rose(chain_select_out) |-> $past(bitstream_end) || $past(bitstream_end, 2))
		else $error("chain select out without stream end");
	err_set_a: assert property (reconfig_n && (id_mismatch || crc_fail || update_fail) |=> !config_error_n)
		else $error("error status not driven low");
	lower_cs_a: assert property (!mode_sense_lower_flash_cs_n_out |-> mode_sense_lower_flash_cs_n_oe)
		else $error("lower select low while not driven");
	upper_cs_a: assert property (!upper_flash_cs_n |-> bus_width == cfg_pins_pkg::W8
		&& !mode_sense_lower_flash_cs_n_out)
		else $error("upper select outside dual quad");
	line_dir_a: assert property (config_data_lines_oe != 0 |-> config_clock_pin_oe
		&& (config_data_lines_oe[4] ? bus_width == cfg_pins_pkg::W8 : config_data_lines_oe == 32'h0000_0001))
		else $error("data line driven out of mode");
	clk_dir_a: assert property (config_clock_pin_oe |-> !mode_sense_lower_flash_cs_n_out)
		else $error("clock driven outside active load");
endmodule : cfg_pins_checker
bind fpga_config_pin_control cfg_pins_checker u_cfg_pins_checker (.*);
`default_nettype wire

// ---- cfg_host_model.sv ----
/* passive configuration host: shifts a word over n lanes, top bits first
   assumes the bench resolves the lines against the device's enables */
`default_nettype none
module cfg_host_model (
	output logic		cclk,
	output logic [31:0]	lines
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cclk = 1'b0;
		lines = 32'hffff_ffff;
	end
	task automatic send(input logic [31:0] w, input int n);
		logic [31:0] t;
		t = w;
		repeat (32 / n)
		begin
			#24 lines = t >> (32 - n);
			#19 cclk = 1'b1;
			#37 cclk = 1'b0;
			t = t << n;
		end
		// clock stands still, lines fall back to the pull-ups
		#24 lines = 32'hffff_ffff;
	endtask : send
endmodule : cfg_host_model
`default_nettype wire

// ---- tb.sv ----
/* bench for the configuration pin controller
   assumes cfg_host_model as host and the checker bound to the design */
`default_nettype none
`include "cfg_pins_cfg.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [8:0] walk = 9'h05f;
	logic	clk, rst, reconfig_n, chain_select_in, test_mode_n, mode_pull, hold_low, tck, tms, tdi;
	logic	alt_config_clock, alt_clock_en, multi_image_en, remote_update, id_mismatch, crc_fail, update_fail;
	logic	bitstream_end, word_ready, config_done_out, config_done_oe, chain_select_out, config_error_n;
	logic	upper_flash_cs_n, mode_sense_lower_flash_cs_n_out, mode_sense_lower_flash_cs_n_oe, user_mode;
	logic	config_clock_pin_out, config_clock_pin_oe, word_valid, tdo, tdo_oe, host_cclk;
	logic	[1:0] remote_image, image_select, image_index;
	logic	[31:0] config_data_lines_out, config_data_lines_oe, word_data, host_lines, got;
	wire logic	config_done_in, mode_sense_lower_flash_cs_n_in, config_clock_pin_in;
	wire logic	[31:0] config_data_lines_in;
	cfg_pins_pkg::width_t	bus_width;
	int	err_total = 0;
	int	total_checks = 0;
	assign config_done_in = !config_done_oe && !hold_low;
	assign mode_sense_lower_flash_cs_n_in = mode_sense_lower_flash_cs_n_oe ? mode_sense_lower_flash_cs_n_out : mode_pull;
	assign config_clock_pin_in = config_clock_pin_oe ? config_clock_pin_out : host_cclk;
	assign config_data_lines_in = (config_data_lines_oe & config_data_lines_out) | (~config_data_lines_oe & host_lines);
	fpga_config_pin_control u_fpga_config_pin_control (.*);
	cfg_host_model u_host (.cclk(host_cclk), .lines(host_lines));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task start(input int w, input logic m);
		reconfig_n <= 1'b0;
		bus_width <= cfg_pins_pkg::width_t'(w[2:0]);
		mode_pull <= m;
		image_select <= w[1:0];
		repeat (8) @(posedge clk);
		reconfig_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask : start
	task get(input logic [31:0] e);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (word_valid !== 1'b1 && n < 60);
		chk("word", e, word_data);
		word_ready <= 1'b1;
		@(posedge clk);
		word_ready <= 1'b0;
	endtask : get
	task tap(input logic m, input logic d);
		tms <= m;
		tdi <= d;
		repeat (10) @(posedge clk);
		tck <= 1'b1;
		repeat (10) @(posedge clk);
		tck <= 1'b0;
		repeat (10) @(posedge clk);
	endtask : tap
	initial
	begin
		{rst, reconfig_n, chain_select_in, test_mode_n, mode_pull, hold_low, tck, tms, tdi} = 9'h1eb;
		{alt_config_clock, alt_clock_en, multi_image_en, remote_update, id_mismatch, crc_fail, update_fail,
			bitstream_end, word_ready} = 9'h040;
		{remote_image, image_select} = 4'h0;
		bus_width = cfg_pins_pkg::W1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("cso_rst", 0, chain_select_out);
		chk("done_rst", 1, config_done_oe);
		chk("done_out", 0, config_done_out);
		chk("err_rst", 1, config_error_n);
		for (int i = 0; i < 6; i++)
		begin
			start(i, 1'b0);
			chk("image", i[1:0], image_index);
			chk("cclk_in", 0, config_clock_pin_oe);
			u_host.send(32'h9ac3_5e17 ^ i, 1 << i);
			get(32'h9ac3_5e17 ^ i);
			chk("cso_load", 0, chain_select_out);
		end
		bitstream_end <= 1'b1;
		@(posedge clk);
		bitstream_end <= 1'b0;
		repeat (10) @(posedge clk);
		chk("cso", 1, chain_select_out);
		chk("done_oe", 0, config_done_oe);
		chk("user_held", 0, user_mode);
		hold_low <= 1'b0;
		repeat (8) @(posedge clk);
		chk("user", 1, user_mode);
		for (int i = 0; i < 9; i++)
			tap(walk[i], 1'b1);
		chk("tdo_on", 1, tdo_oe);
		for (int i = 0; i < 32; i++)
		begin
			got[i] = tdo;
			tap(i == 31, 1'b1);
		end
		chk("idcode", `CFG_IDCODE, got);
		chk("tdo_off", 0, tdo_oe);
		for (int k = 0; k < 2; k++)
		begin
			{chain_select_in, test_mode_n} <= 2'h1 << k;
			start(5, 1'b0);
			u_host.send(32'h0f0f_0f0f, 32);
			repeat (20) @(posedge clk);
			chk("refused", 0, word_valid);
		end
		{chain_select_in, test_mode_n} <= 2'h3;
		start(5, 1'b0);
		for (int k = 0; k < 5; k++)
		begin
			u_host.send(32'hc000_0000 | k, 32);
			repeat (10) @(posedge clk);
			chk("overflow", k < 4, config_error_n);
		end
		for (int k = 0; k < 4; k++)
			get(32'hc000_0000 | k);
		repeat (5) @(posedge clk);
		chk("drained", 0, word_valid);
		for (int k = 0; k < 3; k++)
		begin
			start(5, 1'b0);
			chk("err_clr", 1, config_error_n);
			{id_mismatch, crc_fail, update_fail} <= 3'h4 >> k;
			@(posedge clk);
			{id_mismatch, crc_fail, update_fail} <= 3'h0;
			repeat (3) @(posedge clk);
			chk("err", 0, config_error_n);
		end
		{remote_update, remote_image} <= 3'h6;
		start(3, 1'b1);
		chk("remote", 2, image_index);
		chk("lower_cs", 0, mode_sense_lower_flash_cs_n_out);
		chk("upper_cs", 0, upper_flash_cs_n);
		chk("cclk_out", 1, config_clock_pin_oe);
		chk("line_oe", 32'h0000_0011, config_data_lines_oe);
		reconfig_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("cs_off", 0, mode_sense_lower_flash_cs_n_oe);
		report_and_stop;
	end
	initial
	begin
		#200_000;
		err_total++;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
